// ==== hdl/tbd_params.svh ====
// Constants for the touch button decision block.
// Assumes inclusion by the top module only.
`ifndef TBD_PARAMS_SVH
`define TBD_PARAMS_SVH
`define TBD_ADDR_CFG 8'h21
`define TBD_ADDR_AVG 8'h22
`define TBD_ADDR_NEG 8'h23
`define TBD_ADDR_NCNT 8'h24
`define TBD_ADDR_HYST 8'h25
`define TBD_ADDR_STUCK 8'h26
`define TBD_ADDR_STATE 8'h40
`define TBD_ADDR_EVENT 8'h41
`define TBD_RST_CFG 8'h30
`define TBD_RST_AVG 8'h50
`define TBD_RST_NEG 8'h50
`define TBD_RST_NCNT 8'h01
`define TBD_RST_HYST 8'h0a
`define TBD_RST_STUCK 8'h00
`define TBD_REPORT_HI 7
`define TBD_REPORT_LO 6
`define TBD_IRQ_HI 5
`define TBD_IRQ_LO 4
`define TBD_RDB_HI 3
`define TBD_RDB_LO 2
`define TBD_TDB_HI 1
`define TBD_TDB_LO 0
`define TBD_TICK_SCALE 2
`define TBD_PCT_FULL 100
`define TBD_MULTI_COUNT 3
`endif

// ==== hdl/tbd_pkg.sv ====
// Types for the touch button decision block.
// Assumes the params header is on the include path.
package tbd_pkg;
	typedef enum logic [1:0] {
		TBD_REP_MULTI,
		TBD_REP_SINGLE,
		TBD_REP_RSV2,
		TBD_REP_RSV3
	} tbd_report_t;
	typedef enum logic [1:0] {
		TBD_IRQ_MASKED,
		TBD_IRQ_TOUCH,
		TBD_IRQ_RELEASE,
		TBD_IRQ_BOTH
	} tbd_irq_t;
	typedef logic [15:0] tbd_tick_t;
endpackage

// ==== hdl/tbd_top.sv ====
// Per-sensor button decision logic with an Avalon-MM register slave.
// Assumes scan_strobe_i and second_strobe_i are one-cycle pulses on clk_i,
// ticks and thresholds are stable when scan_strobe_i is high.
// Function
// - Config 7:6 picks all or first-only reporting
// - Config 5:4 picks interrupt cause, default both
// - Config 3:2 release debounce of 1 to 4
// - Config 1:0 touch debounce of 1 to 4
// - Count qualifying scan samples before deciding
// - Touch count starts above threshold plus hysteresis
// - Touch when ticks exceed threshold plus hysteresis
// - Release when ticks drop below threshold minus hysteresis
// - Hysteresis percent shared, 0 to 100, default 10
// - Averaging suspend threshold is four ticks per code
// - Suspend averaging once average reaches that threshold
// - Three sensors suspended together start compensation
// - Negative threshold four ticks per code, default 320
// - Negative counter reaching limit triggers compensation
// - Stuck timeout in seconds, zero disables
// - Stuck touch compensates and forces release
// - Proximity sensors share the same button path
// - Each sensor uses its own threshold
`timescale 1ns/1ps
`include "tbd_params.svh"
module tbd_top #(
	parameter int N_SENSORS = 8,
	parameter int TICK_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Scan timebase and sensor data
	input wire logic scan_strobe_i,
	input wire logic second_strobe_i,
	input wire logic [N_SENSORS*TICK_W-1:0] tick_i,
	input wire logic [N_SENSORS*TICK_W-1:0] average_i,
	input wire logic [N_SENSORS*TICK_W-1:0] sensor_threshold_i,
	// Outputs
	output logic [N_SENSORS-1:0] touched_o,
	output logic [N_SENSORS-1:0] touch_event_o,
	output logic [N_SENSORS-1:0] release_event_o,
	output logic [N_SENSORS-1:0] avg_suspend_o,
	output logic compensate_o,
	output logic irq_o
);
	import tbd_pkg::*;

	// Configuration registers
	logic [7:0] button_config;
	logic [7:0] averaging_suspend_threshold;
	logic [7:0] negative_comp_threshold;
	logic [7:0] negative_count_limit;
	logic [7:0] button_hysteresis_percent;
	logic [7:0] stuck_touch_timeout;
	// Sticky event flags readable by software
	logic [N_SENSORS-1:0] touch_seen;
	logic [N_SENSORS-1:0] release_seen;
	// Single-report owner
	logic owner_valid;
	logic [$clog2(N_SENSORS)-1:0] owner_idx;
	// Per-sensor counters
	logic [2:0] deb_cnt [N_SENSORS];
	logic [7:0] neg_cnt [N_SENSORS];
	logic [7:0] stuck_cnt [N_SENSORS];
	// Per-sensor combinational results
	logic [N_SENSORS-1:0] above_on, below_off, neg_hit, neg_trip, stuck_trip;
	logic [N_SENSORS-1:0] dec_touch, dec_release;
	logic multi_suspend, comp_req;
	logic bus_hit;

	// Debounce code to required sample count
	function automatic logic [2:0] deb_need(input logic [1:0] code);
		deb_need = {1'b0, code} + 3'd1;
	endfunction

	// Register code to tick level, four ticks per code
	function automatic logic [TICK_W+1:0] code_ticks(input logic [7:0] code);
		code_ticks = (TICK_W+2)'({code, 2'b00});
	endfunction

	wire tbd_report_t report_mode = tbd_report_t'(button_config[`TBD_REPORT_HI:`TBD_REPORT_LO]);
	wire tbd_irq_t irq_mode = tbd_irq_t'(button_config[`TBD_IRQ_HI:`TBD_IRQ_LO]);
	wire single_mode = (report_mode == TBD_REP_SINGLE);

	// Per-sensor comparisons
	genvar g;
	generate
		for (g = 0; g < N_SENSORS; g++) begin : g_cmp
			logic [TICK_W-1:0] tk, av, th;
			logic [TICK_W+8:0] hyst_prod;
			logic [TICK_W+1:0] hyst, on_lvl, off_lvl;
			assign tk = tick_i[g*TICK_W +: TICK_W];
			assign av = average_i[g*TICK_W +: TICK_W];
			assign th = sensor_threshold_i[g*TICK_W +: TICK_W];
			// Hysteresis as percent of own threshold
			assign hyst_prod = (TICK_W+9)'(th) * (TICK_W+9)'(button_hysteresis_percent);
			assign hyst = (TICK_W+2)'(hyst_prod / (TICK_W+9)'(`TBD_PCT_FULL));
			assign on_lvl = (TICK_W+2)'(th) + hyst;
			assign off_lvl = (TICK_W+2)'(th) - hyst;
			// Signed ticks; negative never qualifies as touch
			assign above_on[g] = !tk[TICK_W-1] && ((TICK_W+2)'(tk) > on_lvl);
			assign below_off[g] = tk[TICK_W-1] || off_lvl[TICK_W+1]
				? !off_lvl[TICK_W+1] || ($signed(tk) < $signed(off_lvl[TICK_W-1:0]))
				: ((TICK_W+2)'(tk) < off_lvl);
			// Negative side compare against scaled threshold
			assign neg_hit[g] = tk[TICK_W-1]
				&& ((TICK_W+2)'(-tk) > code_ticks(negative_comp_threshold));
			// Average suspend compare
			assign avg_suspend_o[g] = !av[TICK_W-1]
				&& ((TICK_W+2)'(av) >= code_ticks(averaging_suspend_threshold));
			assign neg_trip[g] = neg_hit[g] && (neg_cnt[g] + 8'd1 >= negative_count_limit);
			assign stuck_trip[g] = touched_o[g] && (stuck_touch_timeout != `TBD_RST_STUCK)
				&& second_strobe_i && (stuck_cnt[g] + 8'd1 >= stuck_touch_timeout);
			// Debounce decisions at each scan sample
			assign dec_touch[g] = scan_strobe_i && !touched_o[g] && above_on[g]
				&& (deb_cnt[g] + 3'd1 >= deb_need(button_config[`TBD_TDB_HI:`TBD_TDB_LO]));
			assign dec_release[g] = scan_strobe_i && touched_o[g] && below_off[g]
				&& (deb_cnt[g] + 3'd1 >= deb_need(button_config[`TBD_RDB_HI:`TBD_RDB_LO]));
		end
	endgenerate

	// Count sensors sitting in averaging suspend
	// The count looks at the combinational suspend flags, so it only
	// has meaning at a scan sample when ticks and averages are valid.
	// A large simultaneous rise usually means an environment shift,
	// not several fingers, hence the jump straight to compensation.
	always_comb begin
		int n;
		n = 0;
		for (int i = 0; i < N_SENSORS; i++) begin
			n = n + int'(avg_suspend_o[i]);
		end
		multi_suspend = (n >= `TBD_MULTI_COUNT);
	end

	// Either scan trigger (multi suspend or negative trip) starts compensation this sample
	assign comp_req = scan_strobe_i && (multi_suspend || (|neg_trip));

	// Compensation pulse, one cycle
	// The pulse tells the front end to fetch new baseline offset values.
	// Scan-driven and stuck-driven causes share the same pulse; the
	// front end does not need to know which one fired.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			compensate_o <= 1'b0;
		end else begin
			compensate_o <= comp_req || (|stuck_trip);
		end
	end

	// Per-sensor state and counters; proximity sensors run the same path
	// Priority in the debounce and negative counters: reset, then compensation clear, then
	// the scan-sample update. A scan-driven compensation always wins over a decision
	// taken in the same cycle in the counters and touch state, so no sensor leaves it half-debounced.
	// The debounce counter is shared between touch and release because
	// a sensor only ever waits for one of the two at a time.
	generate
		for (g = 0; g < N_SENSORS; g++) begin : g_st
			// Debounce counter
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					deb_cnt[g] <= 3'd0;
				end else if (comp_req || stuck_trip[g]) begin
					deb_cnt[g] <= 3'd0;
				end else if (scan_strobe_i) begin
					if (dec_touch[g] || dec_release[g]) begin
						deb_cnt[g] <= 3'd0;
					end else if (touched_o[g] ? below_off[g] : above_on[g]) begin
						deb_cnt[g] <= deb_cnt[g] + 3'd1;
					end else begin
						deb_cnt[g] <= 3'd0;
					end
				end
			end
			// Negative counter
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					neg_cnt[g] <= 8'd0;
				end else if (comp_req || stuck_trip[g]) begin
					neg_cnt[g] <= 8'd0;
				end else if (scan_strobe_i) begin
					neg_cnt[g] <= neg_hit[g] ? neg_cnt[g] + 8'd1 : 8'd0;
				end
			end
			// Stuck timer, counts seconds while touched
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					stuck_cnt[g] <= 8'd0;
				end else if (!touched_o[g] || stuck_trip[g]) begin
					stuck_cnt[g] <= 8'd0;
				end else if (second_strobe_i) begin
					stuck_cnt[g] <= stuck_cnt[g] + 8'd1;
				end
			end
			// Touch state
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					touched_o[g] <= 1'b0;
				end else if (comp_req || stuck_trip[g]) begin
					touched_o[g] <= 1'b0;
				end else if (dec_touch[g]) begin
					touched_o[g] <= 1'b1;
				end else if (dec_release[g]) begin
					touched_o[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Reporting filter: single mode keeps only the owner's events
	// In single mode the first reported touch becomes the owner; all
	// other touches and releases are hidden until the owner releases.
	// Hidden sensors still track their touch state internally, so
	// the state register always shows the true touch picture.
	// Reserved report codes fall back to reporting everything.
	logic [N_SENSORS-1:0] rep_touch, rep_release;
	always_comb begin
		logic found;
		found = 1'b0;
		rep_touch = '0;
		rep_release = '0;
		for (int i = 0; i < N_SENSORS; i++) begin
			if (!single_mode) begin
				rep_touch[i] = dec_touch[i];
				rep_release[i] = dec_release[i];
			end else if (owner_valid) begin
				rep_release[i] = dec_release[i] && (owner_idx == i[$clog2(N_SENSORS)-1:0]);
			end else if (dec_touch[i] && !found) begin
				rep_touch[i] = 1'b1;
				found = 1'b1;
			end
		end
	end

	// Owner tracking for single reporting
	// The owner is dropped when it is released by any means, including
	// a stuck timeout or compensation, so reporting cannot lock up.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			owner_valid <= 1'b0;
			owner_idx <= '0;
		end else if (!single_mode || comp_req) begin
			owner_valid <= 1'b0;
		end else if (owner_valid) begin
			if (!touched_o[owner_idx] || stuck_trip[owner_idx]) begin
				owner_valid <= 1'b0;
			end
		end else begin
			for (int i = N_SENSORS - 1; i >= 0; i--) begin
				if (rep_touch[i]) begin
					owner_valid <= 1'b1;
					owner_idx <= i[$clog2(N_SENSORS)-1:0];
				end
			end
		end
	end

	// Event pulses registered
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			touch_event_o <= '0;
			release_event_o <= '0;
		end else begin
			touch_event_o <= rep_touch;
			release_event_o <= rep_release;
		end
	end

	// Interrupt pulse follows reported events under cause select
	// The interrupt is a one-cycle pulse aligned with the event pulses;
	// software learns the cause from the sticky event register.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
		end else begin
			case (irq_mode)
				TBD_IRQ_TOUCH: irq_o <= |rep_touch;
				TBD_IRQ_RELEASE: irq_o <= |rep_release;
				TBD_IRQ_BOTH: irq_o <= |rep_touch || |rep_release;
				default: irq_o <= 1'b0;
			endcase
		end
	end

	// Bus timing overview
	// Writes complete with no wait state: the register takes the data
	// at the same edge at which the master sees waitrequest low.
	// Reads insert one wait state so that the registered read data
	// already stands at the edge where waitrequest is seen low.
	// The first read cycle captures the data into the output flops,
	// the second one releases the master with that data in place.
	// Only the capture cycle has side effects (event clear), so a
	// read held through its wait state clears the events just once.
	// Hazard: a master that drops read during the wait state leaves
	// rd_pend set for one cycle; a read issued in that cycle sees no wait
	// state and completes at once with the data captured for the dropped read.
	logic rd_pend; // Read data captured, answer due this cycle
	logic rd_take; // First cycle of a read: capture data
	assign rd_take = avs_read_i && !rd_pend;
	// Wait state only while a read is still being captured
	assign avs_waitrequest_o = rd_take;
	assign bus_hit = avs_write_i && avs_byteenable_i[0];
	wire rd_event = rd_take && (avs_address_i == `TBD_ADDR_EVENT);

	// Read wait-state tracker, one per read access
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_pend <= 1'b0;
		end else begin
			rd_pend <= rd_take;
		end
	end

	// Register writes
	// Only byte lane 0 carries data; upper write bytes are ignored.
	// Reserved values are stored as written; the logic treats them
	// as described beside each decode.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			button_config <= `TBD_RST_CFG;
			averaging_suspend_threshold <= `TBD_RST_AVG;
			negative_comp_threshold <= `TBD_RST_NEG;
			negative_count_limit <= `TBD_RST_NCNT;
			button_hysteresis_percent <= `TBD_RST_HYST;
			stuck_touch_timeout <= `TBD_RST_STUCK;
		end else if (bus_hit) begin
			case (avs_address_i)
				`TBD_ADDR_CFG: button_config <= avs_writedata_i[7:0];
				`TBD_ADDR_AVG: averaging_suspend_threshold <= avs_writedata_i[7:0];
				`TBD_ADDR_NEG: negative_comp_threshold <= avs_writedata_i[7:0];
				`TBD_ADDR_NCNT: negative_count_limit <= avs_writedata_i[7:0];
				`TBD_ADDR_HYST: button_hysteresis_percent <= avs_writedata_i[7:0];
				`TBD_ADDR_STUCK: stuck_touch_timeout <= avs_writedata_i[7:0];
				default: ;
			endcase
		end
	end

	// Sticky event flags, cleared by reading; new event wins
	// An event landing in the capture cycle of a read survives the
	// clear, so software sees it on its next read and none are lost.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			touch_seen <= '0;
			release_seen <= '0;
		end else begin
			touch_seen <= (rd_event ? '0 : touch_seen) | rep_touch;
			release_seen <= (rd_event ? '0 : release_seen) | rep_release;
		end
	end

	// Read data, zero for unmapped addresses
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (rd_take) begin
			// Captured once; holds through the wait state and after
			case (avs_address_i)
				`TBD_ADDR_CFG: avs_readdata_o <= {24'h00_0000, button_config};
				`TBD_ADDR_AVG: avs_readdata_o <= {24'h00_0000, averaging_suspend_threshold};
				`TBD_ADDR_NEG: avs_readdata_o <= {24'h00_0000, negative_comp_threshold};
				`TBD_ADDR_NCNT: avs_readdata_o <= {24'h00_0000, negative_count_limit};
				`TBD_ADDR_HYST: avs_readdata_o <= {24'h00_0000, button_hysteresis_percent};
				`TBD_ADDR_STUCK: avs_readdata_o <= {24'h00_0000, stuck_touch_timeout};
				`TBD_ADDR_STATE: avs_readdata_o <= 32'(touched_o);
				`TBD_ADDR_EVENT: avs_readdata_o <= 32'({release_seen, touch_seen});
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the touch button decision block.
// Assumes a front end model supplies scan strobes and samples.
`timescale 1ns/1ps
module tb_top;
	localparam int N = 4;
	logic clk_i = 1'b0, rst_b_i = 1'b0, rd_s = 1'b0, wr_s = 1'b0, sec = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000, d;
	logic [63:0] tk = '0, av = '0, tko, avo;
	logic [63:0] th = 64'h00c8_0064_0064_0064; // Sensor 3 has a higher threshold
	logic scan_s, wreq, comp, irq;
	logic [31:0] rdat;
	logic [N-1:0] tch, tev, rev, asus;
	logic [7:0] ra [7] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h30};
	logic [7:0] rv [7] = '{8'h30, 8'h50, 8'h50, 8'h01, 8'h0a, 8'h00, 8'h00};
	int fails = 0, checks = 0, cyc = 0;
	always #2 clk_i = ~clk_i;
	tbd_front_model u_fe (.clk_i, .rst_b_i, .tick_set_i(tk), .avg_set_i(av),
		.scan_strobe_o(scan_s), .tick_o(tko), .average_o(avo));
	tbd_top #(.N_SENSORS(N), .TICK_W(16)) u_dut (.clk_i, .rst_b_i, .avs_address_i(adr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.scan_strobe_i(scan_s), .second_strobe_i(sec), .tick_i(tko), .average_i(avo),
		.sensor_threshold_i(th), .touched_o(tch), .touch_event_o(tev),
		.release_event_o(rev), .avg_suspend_o(asus), .compensate_o(comp), .irq_o(irq));
	// Compare and report
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task finish_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Bus write, held until waitrequest is seen low
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		adr <= a;
		wdat <= {24'h00_0000, v};
		wr_s <= 1'b1;
		do @(posedge clk_i); while (wreq !== 1'b0);
		wr_s <= 1'b0;
	endtask
	// Bus read; held until waitrequest is seen low, data taken at that edge
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		adr <= a;
		rd_s <= 1'b1;
		do @(posedge clk_i); while (wreq !== 1'b0);
		v = rdat;
		rd_s <= 1'b0;
	endtask
	// Set sensor targets and settle after the next scan
	task step(input logic [63:0] t, input logic [63:0] a);
		@(posedge clk_i);
		tk <= t;
		av <= a;
		@(posedge clk_i);
		@(posedge clk_i iff scan_s);
		#1;
	endtask
	// Hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			finish_test;
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], d);
			chk(d, {24'h00_0000, rv[i]});
		end
		wr(8'h21, 8'h31);
		step(64'h0000_0000_0000_006e, '0);
		chk(tch, 4'h0);
		step(64'h0000_0000_0000_006f, '0);
		chk(tch, 4'h0);
		step(64'h0000_0000_0000_006f, '0);
		chk({tch, tev, 3'h0, irq}, {4'h1, 4'h1, 4'h1});
		step(64'h0000_0000_0000_005a, '0);
		chk(tch, 4'h1);
		step(64'h0000_0000_0000_0059, '0);
		chk({tch, rev}, 8'h01);
		wr(8'h21, 8'h70);
		step(64'h0000_0000_0000_006f, '0);
		chk(tev, 4'h1);
		step(64'h0000_006f_0000_006f, '0);
		chk({tch, tev}, 8'h50);
		step(64'h0000_006f_0000_0000, '0);
		chk(rev, 4'h1);
		step('0, '0);
		wr(8'h21, 8'h00);
		step(64'h006f_0000_0000_006f, '0);
		chk({tch, tev, 3'h0, irq}, {4'h1, 4'h1, 4'h0});
		step('0, '0);
		step('0, 64'h0000_0140_0140_0140);
		chk({asus, 3'h0, comp}, 8'h71);
		step('0, '0);
		step(64'h0000_0000_febf_0000, '0);
		chk(comp, 1'b1);
		step('0, '0);
		wr(8'h26, 8'h01);
		step(64'h0000_0000_0000_006f, '0);
		chk(tch, 4'h1);
		@(posedge clk_i);
		sec <= 1'b1;
		@(posedge clk_i);
		sec <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		chk(tch, 4'h0);
		finish_test;
	end
endmodule
bind tbd_top tbd_top_assertions #(.N_SENSORS(N_SENSORS)) u_chk (.clk_i, .rst_b_i,
	.scan_strobe_i, .second_strobe_i, .touched_o, .touch_event_o, .release_event_o,
	.compensate_o, .irq_o);

// ==== testbench/tbd_front_model.sv ====
// Sensor front end model: scan timebase and sampled sensor values.
// Assumes the bench may change target values at any clock edge.
`timescale 1ns/1ps
module tbd_front_model #(
	parameter int W = 64,
	parameter int PERIOD = 16
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] tick_set_i,
	input wire logic [W-1:0] avg_set_i,
	output logic scan_strobe_o,
	output logic [W-1:0] tick_o,
	output logic [W-1:0] average_o
);
	int cnt; // Cycles within one scan period
	// One strobe a period; samples follow the targets a cycle late
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 0;
			scan_strobe_o <= 1'b0;
			tick_o <= '0;
			average_o <= '0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			scan_strobe_o <= (cnt == PERIOD - 1);
			tick_o <= tick_set_i;
			average_o <= avg_set_i;
		end
	end
endmodule

// ==== testbench/tbd_top_assertions.sv ====
// Port checker for the touch button decision block.
// Assumes it is bound to tbd_top and sees only its ports.
`timescale 1ns/1ps
module tbd_top_assertions #(
	parameter int N_SENSORS = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic scan_strobe_i,
	input wire logic second_strobe_i,
	input wire logic [N_SENSORS-1:0] touched_o,
	input wire logic [N_SENSORS-1:0] touch_event_o,
	input wire logic [N_SENSORS-1:0] release_event_o,
	input wire logic compensate_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// A touch event names a touched sensor
	chk_tev_touched: assert property (
		(touch_event_o & ~touched_o) == '0) else $error("touch event on idle sensor");
	// A release event names a released sensor
	chk_rev_idle: assert property (
		(release_event_o & touched_o) == '0) else $error("release event on touched sensor");
	// Events only follow a scan sample
	chk_ev_on_scan: assert property (
		(|touch_event_o) || (|release_event_o) |-> $past(scan_strobe_i))
		else $error("event without scan");
	// Interrupt only with a reported event
	chk_irq_event: assert property (
		irq_o |-> (|touch_event_o) || (|release_event_o)) else $error("irq without event");
	// Compensation start is a single pulse
	chk_comp_pulse: assert property (
		compensate_o |=> !compensate_o) else $error("compensate longer than one cycle");
	// Scan-driven compensation leaves every sensor released
	chk_comp_clear: assert property (
		compensate_o && $past(scan_strobe_i) |-> touched_o == '0)
		else $error("touch kept after comp");
	// Touch state moves only on a scan or second tick
	chk_touch_cause: assert property (
		!$stable(touched_o) |-> $past(scan_strobe_i) || $past(second_strobe_i))
		else $error("touch state moved without cause");
	// Never touch and release one sensor together
	chk_ev_excl: assert property (
		(touch_event_o & release_event_o) == '0) else $error("touch and release together");
endmodule
